/* verilog/spep_error_prioritizer.v */
// Error classification, ACS violation handling and priority logging for a switch port.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - ACS checks apply only when the port is configured as downstream switch port.
// - ACS results are logged and handled by the detecting function only.
// - ACS redirection is normal operation; nothing is logged.
// - ACS blocking is an ACS violation logged in this function's log.
// - No source validation on local or gathered-routed received messages.
// - Blocking violation on non-posted request returns completer-abort completion when ACS wins priority.
// - That completer-abort completion is not logged as completer abort error.
// - ACS violation sets signaled target abort in secondary status.
// - Violation is advisory only if severity nonfatal and TLP non-posted.
// - Advisory goes correctable path; non-advisory goes uncorrectable path.
// - Blocking violation captures TLP header in log, then drops TLP.
// - Direct translated peer failures go to egress control and redirect checks.
// - Priority suppression only for received-TLP errors; others always logged.
// - Internal errors such as ECC faults logged without suppression.
// - Poisoned TLP always sets detected parity flag of its side.
// - Priority: overflow, ECRC, malformed, ACS, multicast, UR/unexpected, poisoned.
// - Same-level errors are exclusive; no tie-break needed.
// - Only the highest-priority error of a TLP is logged and reported.
// - Lower checks still act unless higher error dropped the TLP.
// - All received errors but poison drop the TLP; ECRC drops it only when tlp_ultimate_in is set.
`include "spep_defines.vh"
module spep_error_prioritizer
#(
    parameter HDR_W = 128
)
(
    input wire mclk_in,
    input wire rstn_in,
    // APB slave.
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    // One received TLP's check results, valid for one cycle.
    input wire tlp_valid_in,
    input wire [HDR_W-1:0] tlp_hdr_in,
    input wire tlp_secondary_in,
    input wire tlp_nonposted_in,
    input wire tlp_local_msg_in,
    input wire tlp_ultimate_in,
    input wire err_overflow_in,
    input wire err_ecrc_in,
    input wire err_malformed_in,
    input wire acs_src_fail_in,
    input wire acs_trans_fail_in,
    input wire acs_egress_fail_in,
    input wire acs_dtp2p_fail_in,
    input wire acs_redirect_in,
    input wire err_mc_block_in,
    input wire err_ur_in,
    input wire err_unexp_cpl_in,
    input wire err_poison_in,
    input wire err_internal_in,
    // Results.
    output reg tlp_drop_out,
    output reg tlp_redirect_out,
    output reg cpl_abort_out,
    output reg cor_msg_out,
    output reg uncor_msg_out,
    output reg [2:0] logged_pri_out
);
// ============================================================
// Registers
reg [31:0] ctrl;
reg [`SPEP_UE_WIDTH-1:0] uncorrectable_severity_select;
reg primary_side_status_dpe;
reg secondary_side_status_dpe;
reg signaled_target_abort_flag;
reg [`SPEP_UE_WIDTH-1:0] uncor_log;
reg cor_log;
reg [HDR_W-1:0] hdr_log;
reg hdr_log_valid;

wire dsp_mode = ctrl[`SPEP_CTRL_DSP];
wire wr_en = psel_in & penable_in & pwrite_in;
wire addr_ok = (paddr_in < `SPEP_ADDR_LAST) & (paddr_in[1:0] == 2'h0);

assign pready_out = 1'b1;
assign pslverr_out = psel_in & penable_in & ~addr_ok;

// ============================================================
// Classification
wire acs_dtp2p_egress = acs_dtp2p_fail_in & acs_egress_fail_in;
wire acs_src_eff = acs_src_fail_in & ~tlp_local_msg_in;
wire acs_block = dsp_mode & (acs_src_eff | acs_trans_fail_in | acs_egress_fail_in
    | acs_dtp2p_egress);
wire acs_redir = dsp_mode & acs_redirect_in & ~acs_block;
wire ecrc_drop = err_ecrc_in & tlp_ultimate_in;
wire ovf_drop = err_overflow_in;
wire mal_act = ~ovf_drop & ~ecrc_drop;
wire acs_act = mal_act & ~err_malformed_in;
wire mc_act = acs_act & ~acs_block;
wire ur_act = mc_act & ~err_mc_block_in;
wire drop = ovf_drop | ecrc_drop | (mal_act & err_malformed_in) | (acs_act & acs_block)
    | (mc_act & err_mc_block_in) | (ur_act & (err_ur_in | err_unexp_cpl_in));
wire ur_uc = err_ur_in | err_unexp_cpl_in;

reg [2:0] next_pri;
always @*
begin
    if (err_overflow_in)
        next_pri = `SPEP_PRI_OVF;
    else if (err_ecrc_in)
        next_pri = `SPEP_PRI_ECRC;
    else if (err_malformed_in)
        next_pri = `SPEP_PRI_MAL;
    else if (acs_block)
        next_pri = `SPEP_PRI_ACS;
    else if (err_mc_block_in)
        next_pri = `SPEP_PRI_MC;
    else if (ur_uc)
        next_pri = `SPEP_PRI_UR;
    else if (err_poison_in)
        next_pri = `SPEP_PRI_POISON;
    else
        next_pri = `SPEP_PRI_NONE;
end

reg [`SPEP_UE_WIDTH-1:0] next_bit;
always @*
begin
    next_bit = {`SPEP_UE_WIDTH{1'b0}};
    case (next_pri)
        `SPEP_PRI_OVF: next_bit[`SPEP_UE_OVERFLOW] = 1'b1;
        `SPEP_PRI_ECRC: next_bit[`SPEP_UE_ECRC] = 1'b1;
        `SPEP_PRI_MAL: next_bit[`SPEP_UE_MALFORMED] = 1'b1;
        `SPEP_PRI_ACS: next_bit[`SPEP_UE_ACS] = 1'b1;
        `SPEP_PRI_MC: next_bit[`SPEP_UE_MC_BLOCK] = 1'b1;
        `SPEP_PRI_UR: next_bit[`SPEP_UE_UR] = err_ur_in;
        `SPEP_PRI_POISON: next_bit[`SPEP_UE_POISON] = 1'b1;
        default: next_bit = {`SPEP_UE_WIDTH{1'b0}};
    endcase
    if (next_pri == `SPEP_PRI_UR)
        next_bit[`SPEP_UE_UNEXP_CPL] = err_unexp_cpl_in;
end

// ACS logging and abort completion only when it wins priority; drop and target abort whenever reached.
wire acs_logged = tlp_valid_in & (next_pri == `SPEP_PRI_ACS);
wire acs_reached = tlp_valid_in & acs_act & acs_block;
wire acs_sev_fatal = uncorrectable_severity_select[`SPEP_UE_ACS];
wire acs_advisory = acs_logged & ~acs_sev_fatal & tlp_nonposted_in;
wire gen_cpl_abort = acs_logged & tlp_nonposted_in;
wire log_uncor = tlp_valid_in & (next_pri != `SPEP_PRI_NONE) & ~acs_advisory;
wire log_hdr = tlp_valid_in & (next_pri != `SPEP_PRI_NONE);
wire internal_hit = tlp_valid_in & err_internal_in;

// ============================================================
// Per-TLP results
reg next_drop;
reg next_redirect;
reg next_cpl_abort;
reg next_cor_msg;
reg next_uncor_msg;
always @*
begin
    next_drop = tlp_valid_in & drop;
    next_redirect = tlp_valid_in & acs_redir & mc_act;
    next_cpl_abort = gen_cpl_abort;
    next_cor_msg = acs_advisory;
    next_uncor_msg = log_uncor | internal_hit;
end

always @(posedge mclk_in or negedge rstn_in)
begin
    if (!rstn_in)
    begin
        tlp_drop_out <= 1'b0;
        tlp_redirect_out <= 1'b0;
        cpl_abort_out <= 1'b0;
        cor_msg_out <= 1'b0;
        uncor_msg_out <= 1'b0;
        logged_pri_out <= `SPEP_PRI_NONE;
    end
    else
    begin
        tlp_drop_out <= next_drop;
        tlp_redirect_out <= next_redirect;
        cpl_abort_out <= next_cpl_abort;
        cor_msg_out <= next_cor_msg;
        uncor_msg_out <= next_uncor_msg;
        logged_pri_out <= tlp_valid_in ? next_pri : `SPEP_PRI_NONE;
    end
end

// ============================================================
// Register write strobes
wire ctrl_wr = wr_en & (paddr_in == `SPEP_ADDR_CTRL);
wire sev_wr = wr_en & (paddr_in == `SPEP_ADDR_SEV);
wire sts_wr = wr_en & (paddr_in == `SPEP_ADDR_STS);
wire uncor_wr = wr_en & (paddr_in == `SPEP_ADDR_UNCOR);
wire cor_wr = wr_en & (paddr_in == `SPEP_ADDR_COR);
wire [`SPEP_UE_WIDTH-1:0] uncor_clr = uncor_wr ? pwdata_in[`SPEP_UE_WIDTH-1:0]
    : {`SPEP_UE_WIDTH{1'b0}};
wire hdr_rearm = uncor_wr & (|uncor_clr);

// ============================================================
// Control and severity registers
always @(posedge mclk_in or negedge rstn_in)
begin
    if (!rstn_in)
    begin
        ctrl <= `SPEP_CTRL_RST;
        uncorrectable_severity_select <= `SPEP_SEV_RST;
    end
    else
    begin
        if (ctrl_wr)
            ctrl <= {31'h0, pwdata_in[`SPEP_CTRL_DSP]};
        if (sev_wr)
            uncorrectable_severity_select <= pwdata_in[`SPEP_UE_WIDTH-1:0];
    end
end

// ============================================================
// Status flags: write one to clear; a set in the same cycle wins.
always @(posedge mclk_in or negedge rstn_in)
begin
    if (!rstn_in)
        primary_side_status_dpe <= 1'b0;
    else if (tlp_valid_in && err_poison_in && !tlp_secondary_in)
        primary_side_status_dpe <= 1'b1;
    else if (sts_wr && pwdata_in[`SPEP_STS_PRI_DPE])
        primary_side_status_dpe <= 1'b0;
end

always @(posedge mclk_in or negedge rstn_in)
begin
    if (!rstn_in)
        secondary_side_status_dpe <= 1'b0;
    else if (tlp_valid_in && err_poison_in && tlp_secondary_in)
        secondary_side_status_dpe <= 1'b1;
    else if (sts_wr && pwdata_in[`SPEP_STS_SEC_DPE])
        secondary_side_status_dpe <= 1'b0;
end

// Target abort is flagged whenever the blocking action is reached, logged or not.
always @(posedge mclk_in or negedge rstn_in)
begin
    if (!rstn_in)
        signaled_target_abort_flag <= 1'b0;
    else if (acs_reached)
        signaled_target_abort_flag <= 1'b1;
    else if (sts_wr && pwdata_in[`SPEP_STS_SEC_STA])
        signaled_target_abort_flag <= 1'b0;
end

always @(posedge mclk_in or negedge rstn_in)
begin
    if (!rstn_in)
        cor_log <= 1'b0;
    else if (acs_advisory)
        cor_log <= 1'b1;
    else if (cor_wr && pwdata_in[`SPEP_CE_ADVISORY])
        cor_log <= 1'b0;
end

// ============================================================
// Uncorrectable log: each bit sticks until written with one.
reg [`SPEP_UE_WIDTH-1:0] uncor_set;
always @*
begin
    uncor_set = {`SPEP_UE_WIDTH{1'b0}};
    if (log_uncor)
        uncor_set = next_bit;
    if (internal_hit)
        uncor_set[`SPEP_UE_INTERNAL] = 1'b1;
    // Completer abort is never logged for ACS completions.
    if (acs_advisory)
        uncor_set[`SPEP_UE_ACS] = 1'b1;
end

// Bits cleared in the same cycle as another bit is set keep their clear.
always @(posedge mclk_in or negedge rstn_in)
begin
    if (!rstn_in)
        uncor_log <= {`SPEP_UE_WIDTH{1'b0}};
    else
        uncor_log <= uncor_set | (uncor_log & ~uncor_clr);
end

// ============================================================
// Header log: holds the first logged TLP until the log is cleared.
always @(posedge mclk_in or negedge rstn_in)
begin
    if (!rstn_in)
    begin
        hdr_log <= {HDR_W{1'b0}};
        hdr_log_valid <= 1'b0;
    end
    else if (log_hdr && (!hdr_log_valid || hdr_rearm))
    begin
        hdr_log <= tlp_hdr_in;
        hdr_log_valid <= 1'b1;
    end
    else if (hdr_rearm)
        hdr_log_valid <= 1'b0;
end

// ============================================================
// Read data
reg [31:0] next_rdata;
always @*
begin
    next_rdata = 32'h0000_0000;
    case (paddr_in)
        `SPEP_ADDR_CTRL: next_rdata = ctrl;
        `SPEP_ADDR_SEV: next_rdata[`SPEP_UE_WIDTH-1:0] = uncorrectable_severity_select;
        `SPEP_ADDR_STS:
        begin
            next_rdata[`SPEP_STS_PRI_DPE] = primary_side_status_dpe;
            next_rdata[`SPEP_STS_SEC_DPE] = secondary_side_status_dpe;
            next_rdata[`SPEP_STS_SEC_STA] = signaled_target_abort_flag;
        end
        `SPEP_ADDR_UNCOR: next_rdata[`SPEP_UE_WIDTH-1:0] = uncor_log;
        `SPEP_ADDR_COR: next_rdata[`SPEP_CE_ADVISORY] = cor_log;
        `SPEP_ADDR_HDR0: next_rdata = hdr_log[31:0];
        `SPEP_ADDR_HDR1: next_rdata = hdr_log[63:32];
        `SPEP_ADDR_HDR2: next_rdata = hdr_log[95:64];
        `SPEP_ADDR_HDR3: next_rdata = hdr_log[127:96];
        default: next_rdata = 32'h0000_0000;
    endcase
end

// The word is taken in the setup cycle and held through the access cycle,
// so a read shows the state as it stood one cycle before the access edge.
always @(posedge mclk_in or negedge rstn_in)
begin
    if (!rstn_in)
        prdata_out <= 32'h0000_0000;
    else if (psel_in && !penable_in)
        prdata_out <= next_rdata;
end

endmodule
`default_nettype wire

/* verilog/spep_defines.vh */
// Constants for the switch port error prioritizer: register map, fields and encodings.
`ifndef SPEP_DEFINES_VH
`define SPEP_DEFINES_VH
// ============================================================
// Register byte addresses
`define SPEP_ADDR_CTRL 12'h000
`define SPEP_ADDR_SEV 12'h004
`define SPEP_ADDR_STS 12'h008
`define SPEP_ADDR_UNCOR 12'h00c
`define SPEP_ADDR_COR 12'h010
`define SPEP_ADDR_HDR0 12'h014
`define SPEP_ADDR_HDR1 12'h018
`define SPEP_ADDR_HDR2 12'h01c
`define SPEP_ADDR_HDR3 12'h020
`define SPEP_ADDR_LAST 12'h024
// ============================================================
// Control register fields
`define SPEP_CTRL_DSP 0
`define SPEP_CTRL_RST 32'h0000_0000
// ============================================================
// Status register fields (write one to clear)
`define SPEP_STS_PRI_DPE 0
`define SPEP_STS_SEC_DPE 1
`define SPEP_STS_SEC_STA 2
// ============================================================
// Uncorrectable log bit positions
`define SPEP_UE_INTERNAL 0
`define SPEP_UE_POISON 1
`define SPEP_UE_UNEXP_CPL 2
`define SPEP_UE_UR 3
`define SPEP_UE_MC_BLOCK 4
`define SPEP_UE_ACS 5
`define SPEP_UE_MALFORMED 6
`define SPEP_UE_ECRC 7
`define SPEP_UE_OVERFLOW 8
`define SPEP_UE_WIDTH 9
// Correctable log bit for advisory non-fatal errors.
`define SPEP_CE_ADVISORY 0
// Severity reset: all nonfatal.
`define SPEP_SEV_RST 9'h000
// ============================================================
// Priority levels
`define SPEP_PRI_NONE 3'h0
`define SPEP_PRI_POISON 3'h1
`define SPEP_PRI_UR 3'h2
`define SPEP_PRI_MC 3'h3
`define SPEP_PRI_ACS 3'h4
`define SPEP_PRI_MAL 3'h5
`define SPEP_PRI_ECRC 3'h6
`define SPEP_PRI_OVF 3'h7
`endif

/* tb/spep_asserts.sv */
// Port-level assertions for the switch port error prioritizer.
`timescale 1ns/1ns
`default_nettype none
module spep_checker
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic tlp_valid_in,
    input wire logic tlp_nonposted_in,
    input wire logic err_overflow_in,
    input wire logic err_ecrc_in,
    input wire logic err_malformed_in,
    input wire logic err_poison_in,
    input wire logic tlp_drop_out,
    input wire logic tlp_redirect_out,
    input wire logic cpl_abort_out,
    input wire logic cor_msg_out,
    input wire logic uncor_msg_out,
    input wire logic [2:0] logged_pri_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);
    sequence s_ovf;
        tlp_valid_in && err_overflow_in;
    endsequence
    sequence s_ecrc;
        tlp_valid_in && err_ecrc_in && !err_overflow_in;
    endsequence
    sequence s_mal;
        tlp_valid_in && err_malformed_in && !err_overflow_in && !err_ecrc_in;
    endsequence
    property p_ovf; s_ovf |=> logged_pri_out == 3'h7 && tlp_drop_out; endproperty
    property p_ecrc; s_ecrc |=> logged_pri_out == 3'h6; endproperty
    property p_mal; s_mal |=> logged_pri_out == 3'h5 && tlp_drop_out; endproperty
    property p_acs; logged_pri_out == 3'h4 |-> $past(!err_overflow_in && !err_malformed_in);
    endproperty
    property p_idle; !tlp_valid_in |=> !(tlp_drop_out || tlp_redirect_out || cpl_abort_out
        || cor_msg_out || uncor_msg_out) && logged_pri_out == 3'h0; endproperty
    property p_abort; cpl_abort_out |-> $past(tlp_valid_in && tlp_nonposted_in) && tlp_drop_out;
    endproperty
    property p_adv; cor_msg_out |-> $past(tlp_nonposted_in); endproperty
    property p_poison; logged_pri_out == 3'h1 |-> $past(err_poison_in && !err_ecrc_in); endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not logged at top level");
    a_ecrc: assert property (p_ecrc) else $error("ecrc level wrong");
    a_mal: assert property (p_mal) else $error("malformed level or drop wrong");
    a_acs: assert property (p_acs) else $error("acs logged over higher error");
    a_idle: assert property (p_idle) else $error("result without a tlp");
    a_abort: assert property (p_abort) else $error("abort completion wrong");
    a_adv: assert property (p_adv) else $error("advisory on posted tlp");
    a_poison: assert property (p_poison) else $error("poison level wrong");
endmodule
bind spep_error_prioritizer spep_checker spep_checker_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .tlp_valid_in(tlp_valid_in), .tlp_nonposted_in(tlp_nonposted_in),
    .err_overflow_in(err_overflow_in), .err_ecrc_in(err_ecrc_in),
    .err_malformed_in(err_malformed_in), .err_poison_in(err_poison_in),
    .tlp_drop_out(tlp_drop_out), .tlp_redirect_out(tlp_redirect_out),
    .cpl_abort_out(cpl_abort_out), .cor_msg_out(cor_msg_out),
    .uncor_msg_out(uncor_msg_out), .logged_pri_out(logged_pri_out));
`default_nettype wire

/* tb/spep_link_partner.sv */
// Link partner model presenting one received TLP and its check results per request.
`timescale 1ns/1ns
`default_nettype none
module spep_link_partner
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic send_in,
    input wire logic [16:0] flags_in,
    input wire logic [127:0] hdr_in,
    output logic valid_out,
    output logic [16:0] flags_out,
    output logic [127:0] hdr_out
);
    // Idle lines toggle so stale values are never mistaken for a TLP.
    always @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            valid_out <= 1'b0;
            flags_out <= 17'h0;
            hdr_out <= 128'h0;
        end
        else
        begin
            valid_out <= send_in;
            flags_out <= send_in ? flags_in : ~flags_out;
            hdr_out <= send_in ? hdr_in : ~hdr_out;
        end
    end
endmodule
`default_nettype wire

/* tb/switch_port_error_prioritizer_bench.sv */
// Self-checking bench for the switch port error prioritizer.
`timescale 1ns/1ns
`default_nettype none
`include "spep_defines.vh"
`define CK(a, b) \
    begin \
        n_checks++; \
        if ((a) !== (b)) begin num_errors++; $display("mismatch at %0t got %h exp %h", \
            $time, (a), (b)); end \
    end
module switch_port_error_prioritizer_bench;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, send = 1'b0, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [16:0] fl = 17'h0;
    logic [127:0] hdr = 128'h0;
    wire pready, pslverr, valid;
    wire [16:0] pf;
    wire [127:0] ph;
    wire [7:0] res;
    int num_errors = 0, n_checks = 0;
    // Flag bits: 0 ovf 1 ecrc 2 mal 3 src 4 trans 5 egress 6 dtp2p 7 redirect 8 mc 9 ur
    // 10 unexpected 11 poison 12 internal 13 secondary 14 nonposted 15 local 16 ultimate.
    logic [24:0] tbl [0:7] = '{25'h108018f, 25'h108028e, 25'h108048d, 25'h108088c,
        25'h109008b, 25'h10a008a, 25'h10c008a, 25'h1080009};
    always #50 mclk_in = ~mclk_in;
    spep_link_partner spep_link_partner_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .send_in(send),
        .flags_in(fl), .hdr_in(hdr), .valid_out(valid), .flags_out(pf), .hdr_out(ph));
    spep_error_prioritizer spep_error_prioritizer_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .tlp_valid_in(valid), .tlp_hdr_in(ph), .tlp_secondary_in(pf[13]),
        .tlp_nonposted_in(pf[14]), .tlp_local_msg_in(pf[15]), .tlp_ultimate_in(pf[16]),
        .err_overflow_in(pf[0]), .err_ecrc_in(pf[1]), .err_malformed_in(pf[2]),
        .acs_src_fail_in(pf[3]), .acs_trans_fail_in(pf[4]), .acs_egress_fail_in(pf[5]),
        .acs_dtp2p_fail_in(pf[6]), .acs_redirect_in(pf[7]), .err_mc_block_in(pf[8]),
        .err_ur_in(pf[9]), .err_unexp_cpl_in(pf[10]), .err_poison_in(pf[11]),
        .err_internal_in(pf[12]), .tlp_drop_out(res[7]), .tlp_redirect_out(res[6]),
        .cpl_abort_out(res[5]), .cor_msg_out(res[4]), .uncor_msg_out(res[3]),
        .logged_pri_out(res[2:0]));
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        @(posedge mclk_in);
        while (pready !== 1'b1) @(posedge mclk_in);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CK(rd, e)
    endtask
    task go(input logic [16:0] f);
        @(posedge mclk_in);
        send <= 1'b1;
        fl <= f;
        hdr <= {4{15'h0, f}};
        @(posedge mclk_in);
        send <= 1'b0;
        @(posedge mclk_in);
        #1;
    endtask
    task tlp(input logic [16:0] f, input logic [7:0] e);
        go(f);
        `CK(res, e)
    endtask
    task t_reset;
        rdchk(`SPEP_ADDR_CTRL, 32'h0);
        rdchk(`SPEP_ADDR_STS, 32'h0);
        rdchk(`SPEP_ADDR_LAST, 32'h0);
        `CK(err, 1'b1)
        tlp(17'h4008, 8'h00);
    endtask
    task t_advisory;
        apb(1'b1, `SPEP_ADDR_CTRL, 32'h1);
        tlp(17'h4008, 8'hb4);
        rdchk(`SPEP_ADDR_STS, 32'h4);
        rdchk(`SPEP_ADDR_HDR0, 32'h4008);
        rdchk(`SPEP_ADDR_UNCOR, 32'h20);
        rdchk(`SPEP_ADDR_COR, 32'h1);
        apb(1'b1, `SPEP_ADDR_UNCOR, 32'h1ff);
    endtask
    task t_severe;
        tlp(17'h0010, 8'h8c);
        rdchk(`SPEP_ADDR_HDR3, 32'h10);
        apb(1'b1, `SPEP_ADDR_SEV, 32'h20);
        rdchk(`SPEP_ADDR_SEV, 32'h20);
        tlp(17'h4020, 8'hac);
        apb(1'b1, `SPEP_ADDR_SEV, 32'h0);
    endtask
    task t_exempt;
        tlp(17'h8008, 8'h00);
        tlp(17'h0080, 8'h40);
        tlp(17'h0040, 8'h00);
        tlp(17'h0060, 8'h8c);
    endtask
    task t_priority;
        for (int i = 0; i < 8; i++)
            tlp(tbl[i][24:8], tbl[i][7:0]);
        tlp(17'h0006, 8'h8e);
        tlp(17'h0002, 8'h0e);
    endtask
    task t_parity;
        apb(1'b1, `SPEP_ADDR_STS, 32'h7);
        tlp(17'h2801, 8'h8f);
        rdchk(`SPEP_ADDR_STS, 32'h2);
        apb(1'b1, `SPEP_ADDR_UNCOR, 32'h1ff);
        go(17'h1800);
        rdchk(`SPEP_ADDR_UNCOR, 32'h3);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge mclk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_advisory();
        t_severe();
        t_exempt();
        t_priority();
        t_parity();
        give_verdict();
    end
    initial
    begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
